/* common/mpt_pkg.sv */
// Shared constants and types for the monitor pulse train block
package mpt_pkg;

    // ********************************************************
    // Clock and timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int RATE_FULL_SCALE = 1440;
    localparam int RATE_MAX = 2400;
    // Pulse period at full scale, nearest whole cycle
    localparam int FULL_PERIOD_CYC = (CLK_HZ + RATE_FULL_SCALE / 2) / RATE_FULL_SCALE;
    // Shortest period, rounded up so the rate never passes the ceiling
    localparam int MAX_RATE_PERIOD_CYC = (CLK_HZ + RATE_MAX - 1) / RATE_MAX;
    localparam int CAL_STEP_NS = 1000;
    localparam int CAL_STEP_CYC = CAL_STEP_NS / CLK_PERIOD_NS;

    // ********************************************************
    // Widths
    // ********************************************************
    localparam int VAL_W = 16;
    localparam int CNT_W = 32;
    localparam int DIVD_W = CNT_W + VAL_W;
    localparam int SRC_W = 5;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FREQ_FS = 8'h04;
    localparam logic [7:0] OFS_CURR_FS = 8'h08;
    localparam logic [7:0] OFS_CAL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_PERIOD = 8'h14;
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_WP_BIT = 8;
    localparam int ST_OUT_BIT = 0;
    localparam int ST_ADJ_BIT = 1;
    localparam int ST_CLAMP_BIT = 2;
    localparam int ST_ZERO_BIT = 3;

    // ********************************************************
    // Reset values and source codes
    // ********************************************************
    localparam logic [SRC_W-1:0] SRC_FREQ = 5'h01;
    localparam logic [SRC_W-1:0] SRC_CURR = 5'h02;
    localparam logic [SRC_W-1:0] SRC_REF = 5'h15;
    localparam logic [SRC_W-1:0] SRC_RST = SRC_FREQ;
    // Frequency in 0.01 Hz, 60 Hz
    localparam logic [VAL_W-1:0] FREQ_FS_RST = 16'h1770;
    // Current in 0.01 A, stands for the rated current
    localparam logic [VAL_W-1:0] CURR_FS_RST = 16'h0100;
    // Width in steps of CAL_STEP_NS
    localparam logic [VAL_W-1:0] CAL_RST = 16'h0064;
    localparam logic [VAL_W-1:0] CAL_MAX = 16'hFFFF;
    localparam logic [VAL_W-1:0] CAL_DIAL_STEP = 16'h0001;

    // ********************************************************
    // Types
    // ********************************************************
    typedef struct packed {
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] width;
    } mpt_pulse_cfg_s;

    typedef struct packed {
        logic item_sel;
        logic set_key;
        logic dial_inc;
        logic dial_dec;
    } mpt_keypad_s;

    typedef enum logic {KP_IDLE, KP_ADJUST} mpt_kp_state_e;

endpackage

/* logic/mpt_divider.sv */
// Sequential restoring divider for the period calculation
`timescale 1ns/1ps
module mpt_divider
    import mpt_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request
    input wire logic start,
    input wire logic [DIVD_W-1:0] dividend,
    input wire logic [VAL_W-1:0] divisor,
    // Result
    output logic busy,
    output logic done,
    output logic [DIVD_W-1:0] quotient
);
    import mpt_pkg::*;

    localparam logic [5:0] STEPS = 6'(DIVD_W);

    logic [VAL_W:0] rem_r;
    logic [VAL_W-1:0] dsr_r;
    logic [5:0] cnt_r;
    logic [VAL_W:0] shifted;

    assign shifted = {rem_r[VAL_W-1:0], quotient[DIVD_W-1]};
    assign busy = (cnt_r != 6'h00);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rem_r <= '0;
            dsr_r <= '0;
            cnt_r <= 6'h00;
            quotient <= '0;
            done <= 1'b0;
        end
        else
        begin
            done <= (cnt_r == 6'h01);
            if (start && !busy)
            begin
                rem_r <= '0;
                dsr_r <= divisor;
                quotient <= dividend;
                cnt_r <= STEPS;
            end
            else if (busy)
            begin
                cnt_r <= cnt_r - 6'h01;
                if (shifted >= {1'b0, dsr_r})
                begin
                    rem_r <= shifted - {1'b0, dsr_r};
                    quotient <= {quotient[DIVD_W-2:0], 1'b1};
                end
                else
                begin
                    rem_r <= shifted;
                    quotient <= {quotient[DIVD_W-2:0], 1'b0};
                end
            end
        end
    end
endmodule

/* logic/mpt_monitor_pulse.sv */
// Monitor pulse train generator with APB registers and keypad trim
//
// Operation
// [RQ1] 1440 pulses/s at full-scale value
// [RQ2] Clamp pulse rate at 2400 pulses/s
// [RQ3] High time set by width calibration
// [RQ4] Period from frequency or current full scale
// [RQ5] Source code 21 gives fixed 1440/s
// [RQ6] Defaults: 60Hz gives 1440/s
// [RQ7] Defaults saturate at 100Hz and above
// [RQ8] Width trim accepted while drive runs
// [RQ9] Stopped trim for operation-independent sources
// [RQ10] Set enters trim, dial live, set commits
// [RQ11] Settings writable despite write protect
// [RQ12] Rate linear in monitored quantity
// [RQ13] Counted period, reload at pulse boundary
// [RQ14] Zero rate holds output low
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module mpt_monitor_pulse
    import mpt_pkg::*;
#(
    parameter int FULL_PERIOD_CYC_P = FULL_PERIOD_CYC,
    parameter int MAX_RATE_PERIOD_CYC_P = MAX_RATE_PERIOD_CYC
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Monitored quantities and drive state
    input wire logic [mpt_pkg::VAL_W-1:0] mon_freq,
    input wire logic [mpt_pkg::VAL_W-1:0] mon_current,
    input wire logic drive_running,
    // Operator keypad
    input wire mpt_pkg::mpt_keypad_s keypad,
    // Meter output
    output logic monitor_pulse_out
);
    import mpt_pkg::*;

    localparam logic [CNT_W-1:0] FULL_P = CNT_W'(FULL_PERIOD_CYC_P);
    localparam logic [CNT_W-1:0] MINP_P = CNT_W'(MAX_RATE_PERIOD_CYC_P);
    localparam logic [CNT_W-1:0] STEP_P = CNT_W'(CAL_STEP_CYC);
    // Start cycle to result in calc_period_r: one load, one step per bit, one capture
    localparam int RESULT_LAT = DIVD_W + 2;

    logic [SRC_W-1:0] monitor_source_select_r;
    logic parameter_write_protect_r;
    logic [VAL_W-1:0] frequency_full_scale_r;
    logic [VAL_W-1:0] current_full_scale_r;
    logic [VAL_W-1:0] pulse_width_calibration_r;
    logic [VAL_W-1:0] adj_r;
    mpt_kp_state_e kp_r;
    logic [CNT_W-1:0] calc_period_r;
    logic calc_zero_r;
    logic req_zero_r;

    logic wr_en;
    logic setup;
    logic mapped;
    logic [31:0] rd_nxt;
    logic [VAL_W-1:0] sel_value;
    logic [VAL_W-1:0] sel_fs;
    logic div_start;
    logic div_busy;
    logic div_done;
    logic [DIVD_W-1:0] div_q;
    logic [CNT_W-1:0] period_sel;
    logic [CNT_W-1:0] width_raw;
    logic [VAL_W-1:0] cal_live;
    logic rate_nz;
    logic clamped;
    logic trim_allowed;
    logic commit;
    mpt_pulse_cfg_s cfg;

    // ********************************************************
    // APB decode
    // ********************************************************
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign pready = psel && penable;
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_FREQ_FS) || (paddr == OFS_CURR_FS)
                 || (paddr == OFS_CAL) || (paddr == OFS_STATUS) || (paddr == OFS_PERIOD);

    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        case (paddr)
            OFS_CTRL:
            begin
                rd_nxt[CTRL_SRC_LSB +: SRC_W] = monitor_source_select_r;
                rd_nxt[CTRL_WP_BIT] = parameter_write_protect_r;
            end
            OFS_FREQ_FS: rd_nxt[VAL_W-1:0] = frequency_full_scale_r;
            OFS_CURR_FS: rd_nxt[VAL_W-1:0] = current_full_scale_r;
            OFS_CAL: rd_nxt[VAL_W-1:0] = pulse_width_calibration_r;
            OFS_STATUS:
            begin
                rd_nxt[ST_OUT_BIT] = monitor_pulse_out;
                rd_nxt[ST_ADJ_BIT] = (kp_r == KP_ADJUST);
                rd_nxt[ST_CLAMP_BIT] = clamped;
                rd_nxt[ST_ZERO_BIT] = !rate_nz;
            end
            OFS_PERIOD: rd_nxt = period_sel;
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    // Read data and error are captured in setup, so access needs no wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= !mapped || (pwrite && (paddr == OFS_STATUS || paddr == OFS_PERIOD));
        end
    end

    // ********************************************************
    // Settings registers
    // ********************************************************
    // The write-protect bit is kept for software but never gates these
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            monitor_source_select_r <= SRC_RST;
            parameter_write_protect_r <= 1'b0;
            frequency_full_scale_r <= FREQ_FS_RST; // RQ6
            current_full_scale_r <= CURR_FS_RST;
        end
        else if (wr_en)
        begin
            case (paddr)
                OFS_CTRL:
                begin
                    monitor_source_select_r <= pwdata[CTRL_SRC_LSB +: SRC_W];
                    parameter_write_protect_r <= pwdata[CTRL_WP_BIT];
                end
                OFS_FREQ_FS: frequency_full_scale_r <= pwdata[VAL_W-1:0]; // RQ11
                OFS_CURR_FS: current_full_scale_r <= pwdata[VAL_W-1:0]; // RQ11
                default: ;
            endcase
        end
    end

    // ********************************************************
    // Keypad trim
    // ********************************************************
    // Reference output runs without the drive, so trim is allowed stopped
    assign trim_allowed = drive_running || (monitor_source_select_r == SRC_REF); // RQ8 RQ9
    assign commit = (kp_r == KP_ADJUST) && keypad.set_key;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            kp_r <= KP_IDLE;
            adj_r <= CAL_RST;
        end
        else
        begin
            case (kp_r)
                KP_IDLE:
                begin
                    adj_r <= pulse_width_calibration_r;
                    if (keypad.item_sel && keypad.set_key && trim_allowed)
                        kp_r <= KP_ADJUST; // RQ10
                end
                KP_ADJUST:
                begin
                    if (keypad.set_key)
                        kp_r <= KP_IDLE;
                    else if (keypad.dial_inc && adj_r != CAL_MAX)
                        adj_r <= adj_r + CAL_DIAL_STEP; // RQ10
                    else if (keypad.dial_dec && adj_r != '0)
                        adj_r <= adj_r - CAL_DIAL_STEP; // RQ10
                end
                default: kp_r <= KP_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pulse_width_calibration_r <= CAL_RST;
        else if (commit)
            pulse_width_calibration_r <= adj_r; // RQ10
        else if (wr_en && paddr == OFS_CAL)
            pulse_width_calibration_r <= pwdata[VAL_W-1:0]; // RQ11
    end

    // ********************************************************
    // Period calculation
    // ********************************************************
    always_comb
    begin
        case (monitor_source_select_r)
            SRC_FREQ:
            begin
                sel_value = mon_freq;
                sel_fs = frequency_full_scale_r; // RQ4
            end
            SRC_CURR:
            begin
                sel_value = mon_current;
                sel_fs = current_full_scale_r; // RQ4
            end
            default:
            begin
                sel_value = '0;
                sel_fs = '0;
            end
        endcase
    end

    // Period = full-scale period * full scale / value, inverse of the rate
    assign div_start = !div_busy;

    mpt_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(div_start),
        .dividend(DIVD_W'(FULL_P) * DIVD_W'(sel_fs)), // RQ1 RQ12
        .divisor(sel_value),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_q)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_zero_r <= 1'b1;
            calc_zero_r <= 1'b1;
            calc_period_r <= '0;
        end
        else
        begin
            if (div_start)
                req_zero_r <= (sel_value == '0);
            if (div_done)
            begin
                calc_zero_r <= req_zero_r;
                calc_period_r <= (div_q[DIVD_W-1:CNT_W] != '0) ? '1 : div_q[CNT_W-1:0];
            end
        end
    end

    // A stale result lasts one divide, about fifty cycles
    assign clamped = (monitor_source_select_r != SRC_REF) && (calc_period_r < MINP_P);
    assign rate_nz = (monitor_source_select_r == SRC_REF) || !calc_zero_r; // RQ14

    always_comb
    begin
        if (monitor_source_select_r == SRC_REF)
            period_sel = FULL_P; // RQ5
        else if (clamped)
            period_sel = MINP_P; // RQ2 RQ7
        else
            period_sel = calc_period_r;
    end

    // ********************************************************
    // Width and output
    // ********************************************************
    assign cal_live = (kp_r == KP_ADJUST) ? adj_r : pulse_width_calibration_r; // RQ10
    assign width_raw = CNT_W'(cal_live) * STEP_P;
    assign cfg.period = period_sel;
    assign cfg.width = (width_raw >= period_sel) ? period_sel - 32'h0000_0001 : width_raw; // RQ3

    mpt_pulse_gen u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .enable(rate_nz),
        .cfg(cfg),
        .pulse_out(monitor_pulse_out)
    );

    // ********************************************************
    // Checks
    // ********************************************************
    property p_ref_rate;
        @(posedge pclk) disable iff (!presetn)
            (monitor_source_select_r == SRC_REF) |-> (cfg.period == FULL_P && rate_nz);
    endproperty
    a_ref_rate: assert property (p_ref_rate) else $error("reference source not at full-scale rate"); // RQ5

    property p_max_rate;
        @(posedge pclk) disable iff (!presetn) rate_nz |-> (cfg.period >= MINP_P);
    endproperty
    a_max_rate: assert property (p_max_rate) else $error("pulse rate above ceiling"); // RQ2

    property p_width_fits;
        @(posedge pclk) disable iff (!presetn) rate_nz |-> (cfg.width < cfg.period);
    endproperty
    a_width_fits: assert property (p_width_fits) else $error("width not below period"); // RQ3

    property p_full_scale;
        @(posedge pclk) disable iff (!presetn)
            (div_start && sel_value == sel_fs && sel_fs != '0) |-> ##RESULT_LAT (calc_period_r == FULL_P);
    endproperty
    a_full_scale: assert property (p_full_scale) else $error("full scale not at full-scale period"); // RQ1

    property p_dial_live;
        @(posedge pclk) disable iff (!presetn)
            (kp_r == KP_ADJUST && !keypad.set_key && keypad.dial_inc && adj_r != CAL_MAX)
            |=> (cal_live == $past(adj_r) + CAL_DIAL_STEP);
    endproperty
    a_dial_live: assert property (p_dial_live) else $error("dial did not change live width"); // RQ10

    property p_commit;
        @(posedge pclk) disable iff (!presetn)
            commit |=> (kp_r == KP_IDLE && pulse_width_calibration_r == $past(adj_r));
    endproperty
    a_commit: assert property (p_commit) else $error("set key did not commit width"); // RQ10

    property p_no_stop_trim;
        @(posedge pclk) disable iff (!presetn)
            (kp_r == KP_IDLE && !drive_running && monitor_source_select_r != SRC_REF) |=> (kp_r == KP_IDLE);
    endproperty
    a_no_stop_trim: assert property (p_no_stop_trim) else $error("trim entered while stopped"); // RQ9

    property p_wp_write;
        @(posedge pclk) disable iff (!presetn)
            (wr_en && paddr == OFS_FREQ_FS && parameter_write_protect_r)
            |=> (frequency_full_scale_r == $past(pwdata[VAL_W-1:0]));
    endproperty
    a_wp_write: assert property (p_wp_write) else $error("full scale write refused"); // RQ11
endmodule

/* logic/mpt_pulse_gen.sv */
// Period and high-time counter that drives the pulse train
`timescale 1ns/1ps
module mpt_pulse_gen
    import mpt_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Settings
    input wire logic enable,
    input wire mpt_pkg::mpt_pulse_cfg_s cfg,
    // Pulse output
    output logic pulse_out
);
    import mpt_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] width_r;
    logic boundary;

    assign boundary = (cnt_r == '0);

    // ********************************************************
    // Counting
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= '0;
            period_r <= '0;
            width_r <= '0;
            pulse_out <= 1'b0;
        end
        else if (!enable)
        begin
            cnt_r <= '0;
            pulse_out <= 1'b0; // RQ14
        end
        else if (boundary)
        begin
            // New settings only here, so no pulse is cut short
            period_r <= cfg.period; // RQ13
            width_r <= cfg.width; // RQ3
            cnt_r <= cfg.period - 32'h0000_0001;
            pulse_out <= (cfg.width != '0);
        end
        else
        begin
            cnt_r <= cnt_r - 32'h0000_0001;
            pulse_out <= ((period_r - cnt_r) < width_r);
        end
    end

    property p_zero_low;
        @(posedge pclk) disable iff (!presetn) !enable |=> !pulse_out;
    endproperty
    a_zero_low: assert property (p_zero_low) else $error("pulse high while disabled"); // RQ14

    property p_hold_mid;
        @(posedge pclk) disable iff (!presetn)
            (enable && !boundary) |=> ($stable(period_r) && $stable(width_r));
    endproperty
    a_hold_mid: assert property (p_hold_mid) else $error("settings changed mid pulse"); // RQ13
endmodule

/* verification/mpt_monitor_pulse_test.sv */
// Self-checking bench for the monitor pulse train block
`timescale 1ns/1ps
module mpt_monitor_pulse_test;
    import mpt_pkg::*;
    localparam int FP = 1440;
    localparam int MP = 864;
    localparam int SETTLE = 6000;
    localparam int LIMIT = 95000;
    typedef struct {
        logic [SRC_W-1:0] src;
        logic [VAL_W-1:0] ffs;
        logic [VAL_W-1:0] cfs;
        logic [VAL_W-1:0] mf;
        logic [VAL_W-1:0] mc;
        logic [31:0] per;
    } mpt_row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, drive_running, monitor_pulse_out, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, m_period, m_width, m_count, c;
    logic [VAL_W-1:0] mon_freq, mon_current;
    mpt_keypad_s keypad;
    int err_count, tests_run, cycles;
    logic [7:0] da [4] = '{OFS_CTRL, OFS_FREQ_FS, OFS_CURR_FS, OFS_CAL};
    logic [31:0] dv [4] = '{32'h00000001, 32'h00001770, 32'h00000100, 32'h00000064};
    // Source, freq scale, current scale, freq, current, period in cycles
    mpt_row_s rows [7] = '{
        '{SRC_FREQ, 16'h1770, 16'h0100, 16'h1770, 16'h0000, 32'h000005A0},
        '{SRC_FREQ, 16'h1770, 16'h0100, 16'h0BB8, 16'h0000, 32'h00000B40},
        '{SRC_FREQ, 16'h1770, 16'h0100, 16'h2710, 16'h0000, 32'h00000360},
        '{SRC_FREQ, 16'h1770, 16'h0100, 16'h2EE0, 16'h0000, 32'h00000360},
        '{SRC_FREQ, 16'h2710, 16'h0100, 16'h2710, 16'h0000, 32'h000005A0},
        '{SRC_CURR, 16'h1770, 16'h0100, 16'h1770, 16'h0080, 32'h00000B40},
        '{SRC_REF, 16'h1770, 16'h0100, 16'h0000, 16'h0000, 32'h000005A0}};

    mpt_monitor_pulse #(.FULL_PERIOD_CYC_P(FP), .MAX_RATE_PERIOD_CYC_P(MP)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mon_freq(mon_freq), .mon_current(mon_current),
        .drive_running(drive_running), .keypad(keypad), .monitor_pulse_out(monitor_pulse_out));
    mpt_pulse_meter u_meter (.pclk(pclk), .presetn(presetn), .pulse_in(monitor_pulse_out),
        .period_r(m_period), .width_r(m_width), .count_r(m_count));

    // ****************************************
    // Bus, keypad and compare tasks
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the bench run limit ends a wait for the slave
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One-cycle press, item kept shown afterwards
    task automatic kp(input logic [3:0] v);
        keypad <= mpt_keypad_s'(v);
        @(posedge pclk);
        keypad <= mpt_keypad_s'({v[3], 3'b000});
        @(posedge pclk);
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Stuck scenarios end the run instead of hanging
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            err_count++;
            $display("ERROR at %0t: run limit reached", $time);
            give_verdict;
        end
    end

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {presetn, psel, penable, pwrite, drive_running} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        mon_freq = 16'h0000;
        mon_current = 16'h0000;
        keypad = mpt_keypad_s'(4'h0);
        err_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (5) @(posedge pclk);
        chk1(monitor_pulse_out, 1'b0, "out in reset");
        presetn <= 1'b1;
        foreach (da[i])
        begin
            apb(1'b0, da[i], 32'h00000000, rd, er);
            chk32(rd, dv[i], "reset value");
        end
        apb(1'b0, 8'h18, 32'h00000000, rd, er);
        chk1(er, 1'b1, "unmapped error");
        apb(1'b1, OFS_STATUS, 32'h0000000F, rd, er);
        chk1(er, 1'b1, "read-only error");
        apb(1'b1, OFS_CTRL, 32'h00000101, rd, er);
        apb(1'b1, OFS_CAL, 32'h00000005, rd, er);
        chk1(er, 1'b0, "protected write");
        apb(1'b0, OFS_CAL, 32'h00000000, rd, er);
        chk32(rd, 32'h00000005, "protected cal");
        $display("register test done");
        foreach (rows[i])
        begin
            apb(1'b1, OFS_FREQ_FS, {16'h0000, rows[i].ffs}, rd, er);
            apb(1'b1, OFS_CURR_FS, {16'h0000, rows[i].cfs}, rd, er);
            apb(1'b1, OFS_CTRL, {27'h0000000, rows[i].src}, rd, er);
            mon_freq <= rows[i].mf;
            mon_current <= rows[i].mc;
            repeat (SETTLE) @(posedge pclk);
            chk32(m_period, rows[i].per, "period");
            chk32(m_width, 32'h000001F4, "width");
            apb(1'b0, OFS_PERIOD, 32'h00000000, rd, er);
            chk32(rd, rows[i].per, "period reg");
            apb(1'b0, OFS_STATUS, 32'h00000000, rd, er);
            chk1(rd[ST_CLAMP_BIT], i == 3, "clamp flag");
            $display("row %0d done", i);
        end
        for (int s = 0; s < 2; s++)
        begin
            apb(1'b1, OFS_CTRL, (s == 0) ? 32'h00000001 : 32'h00000003, rd, er);
            mon_freq <= 16'h0000;
            repeat (SETTLE / 2) @(posedge pclk);
            c = m_count;
            repeat (SETTLE / 2) @(posedge pclk);
            chk32(m_count, c, "zero rate pulses");
            chk1(monitor_pulse_out, 1'b0, "zero rate level");
            apb(1'b0, OFS_STATUS, 32'h00000000, rd, er);
            chk32(rd, 32'h00000008, "zero rate status");
        end
        $display("zero rate test done");
        apb(1'b1, OFS_CTRL, 32'h00000001, rd, er);
        mon_freq <= 16'h1770;
        drive_running <= 1'b1;
        kp(4'hC);
        apb(1'b0, OFS_STATUS, 32'h00000000, rd, er);
        chk1(rd[ST_ADJ_BIT], 1'b1, "adjust entered");
        repeat (3) kp(4'hA);
        repeat (SETTLE) @(posedge pclk);
        chk32(m_width, 32'h00000320, "live width");
        apb(1'b0, OFS_CAL, 32'h00000000, rd, er);
        chk32(rd, 32'h00000005, "cal before commit");
        kp(4'hC);
        apb(1'b0, OFS_CAL, 32'h00000000, rd, er);
        chk32(rd, 32'h00000008, "cal committed");
        drive_running <= 1'b0;
        kp(4'hC);
        apb(1'b0, OFS_STATUS, 32'h00000000, rd, er);
        chk1(rd[ST_ADJ_BIT], 1'b0, "stopped entry refused");
        apb(1'b1, OFS_CTRL, {27'h0000000, SRC_REF}, rd, er);
        kp(4'hC);
        apb(1'b0, OFS_STATUS, 32'h00000000, rd, er);
        chk1(rd[ST_ADJ_BIT], 1'b1, "reference entry");
        kp(4'h9);
        kp(4'hC);
        apb(1'b0, OFS_CAL, 32'h00000000, rd, er);
        chk32(rd, 32'h00000007, "stopped trim");
        $display("keypad test done");
        give_verdict;
    end
endmodule

/* verification/mpt_pulse_meter.sv */
// Behavioural pulse counter and timer standing at the meter terminals
`timescale 1ns/1ps
module mpt_pulse_meter
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pulse terminal
    input wire logic pulse_in,
    // Measurements
    output logic [31:0] period_r,
    output logic [31:0] width_r,
    output logic [31:0] count_r
);
    logic prev_r;
    logic [31:0] since_r;

    // Timed from each rising edge, so a lost pulse shows as a long period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_r <= 1'b0;
            since_r <= 32'h00000000;
            period_r <= 32'h00000000;
            width_r <= 32'h00000000;
            count_r <= 32'h00000000;
        end
        else
        begin
            prev_r <= pulse_in;
            since_r <= (pulse_in && !prev_r) ? 32'h00000001 : since_r + 32'h00000001;
            if (pulse_in && !prev_r)
            begin
                period_r <= since_r;
                count_r <= count_r + 32'h00000001;
            end
            if (!pulse_in && prev_r)
                width_r <= since_r;
        end
    end
endmodule
